// File: rtl/clhp_pkg.sv
// Constants, types and timing counts for the character display host port
package clhp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int EXEC_NS       = 38000;     // Ordinary instruction or data write
    localparam int LONG_EXEC_NS  = 1520000;   // Clear or return home
    localparam int EXEC_CYC      = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_EXEC_CYC = (LONG_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_CYC       = 1024;      // Clock cycles per scanned common row
    localparam int BUSY_W        = 18;

    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int CELLS         = 16;        // One line of sixteen cells
    localparam int HALF_CELLS    = 8;
    localparam int COMMONS       = 16;        // One-sixteenth duty
    localparam int DOT_COLS      = 5;
    localparam int CODE_DEPTH    = 80;        // Character code store
    localparam int GLYPH_DEPTH   = 64;        // Custom glyph store, 64 x 8
    localparam int ROM_SMALL     = 192;       // Fixed glyphs, 5 x 7 font
    localparam int ROM_LARGE     = 32;        // Fixed glyphs, 5 x 10 font
    localparam logic [6:0] SECOND_BASE = 7'h40; // Address group for cells 9..16
    localparam logic [6:0] GROUP_LAST  = 7'h27; // Last address of first group
    localparam logic [6:0] SECOND_LAST = 7'h67; // Last address of second group
    localparam logic [6:0] GROUP_SPAN  = 7'd40; // Codes held per group
    localparam logic [2:0] CURSOR_LINE = 3'd7;  // Cursor row below the 5 x 7 font
    localparam logic       DL_RESET    = 1'b1;  // Eight-bit bus after reset

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic target_select;  // High: character data, low: instruction path
        logic dir_read;       // High: device to host
        logic strobe;         // Transfer strobe
    } clhp_ctl_t;

    typedef enum logic [0:0] {
        NIB_HI = 1'b0,
        NIB_LO = 1'b1
    } clhp_nib_t;

endpackage : clhp_pkg

// File: rtl/clhp_top.sv
// Host port, code and glyph stores and row scanner of a 16 x 1 character display
// Function
// - Target select high picks character data, low picks instruction path.
// - Port works with a four-bit or an eight-bit host data path.
// - Cells 1-8 show addresses 00-07, cells 9-16 show 40-47 hex.
// - Sixteen cells on one line, five-by-seven font plus cursor row.
// - Custom glyph store of 64 bytes, eight glyphs of five by eight.
// - Character code store holds up to eighty eight-bit codes.
// - Fixed glyphs are a stand-in pattern from code bits 4..0 and the row.
// - Sixteen common rows are scanned in turn at one-sixteenth duty.
// - Data write outside a busy period stores the byte at the addressed code or glyph location.
// - Instruction read returns busy on bit 7 and pointer below.
`timescale 1ns/100ps
module clhp_top
    import clhp_pkg::*;
#(
    parameter int EXEC_CYCLES      = EXEC_CYC,
    parameter int LONG_EXEC_CYCLES = LONG_EXEC_CYC,
    parameter int ROW_CYCLES       = ROW_CYC
) (
    input  wire logic               CLK_SYS_I,
    input  wire logic               RST_B_I,
    input  wire clhp_pkg::clhp_ctl_t HOST_CTL_I,
    input  wire logic [7:0]         HOST_BUS_LINES_I,
    output logic      [7:0]         HOST_BUS_LINES_O,
    output logic                    HOST_BUS_LINES_OE_O,
    output logic      [15:0]        COMMON_ROW_O,
    output logic      [39:0]        SEGMENT_DOTS_O
);
    import clhp_pkg::*;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [7:0]        char_code_ram [CODE_DEPTH];
    logic [7:0]        custom_glyph_ram [GLYPH_DEPTH];
    logic              strobe_q;
    clhp_nib_t         nib_q;
    logic [3:0]        hi_nib_q;
    logic              bus8_q;
    logic [6:0]        ram_pointer_q;
    logic              glyph_sel_q;
    logic              disp_on_q;
    logic              cursor_on_q;
    logic [BUSY_W-1:0] busy_cnt_q;
    logic              internal_op_flag;
    logic [15:0]       tick_q;
    logic [3:0]        row_q;
    logic [39:0]       seg_d;

    logic              fall;
    logic              byte_done;
    logic [7:0]        in_byte;
    logic              wr_byte;
    logic              rd_byte;
    logic [6:0]        code_idx;
    logic              code_valid;
    logic [7:0]        rd_data;
    logic [7:0]        out_byte;

    // ------------------------------------------------------------
    // Strobe and nibble pairing
    // ------------------------------------------------------------
    // Inputs are synchronous, so one stage is enough to see the falling edge
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= HOST_CTL_I.strobe;
        end
    end

    assign fall      = strobe_q & ~HOST_CTL_I.strobe;
    assign byte_done = fall & (bus8_q | (nib_q == NIB_LO));
    assign in_byte   = bus8_q ? HOST_BUS_LINES_I : {hi_nib_q, HOST_BUS_LINES_I[7:4]};
    // Writes during an internal operation are dropped, reads still served
    assign wr_byte   = byte_done & ~HOST_CTL_I.dir_read & ~internal_op_flag;
    assign rd_byte   = byte_done & HOST_CTL_I.dir_read;

    // High nibble first on lines 7..4, low nibble second
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            nib_q    <= NIB_HI;
            hi_nib_q <= 4'h0;
        end else if (fall && !bus8_q) begin
            nib_q    <= (nib_q == NIB_HI) ? NIB_LO : NIB_HI;
            hi_nib_q <= HOST_BUS_LINES_I[7:4];
        end else if (bus8_q) begin
            nib_q    <= NIB_HI;
        end
    end

    // ------------------------------------------------------------
    // Address mapping of the code store
    // ------------------------------------------------------------
    // Two groups of forty: 00..27 and 40..67; gap addresses hold nothing
    function automatic logic [6:0] code_index(input logic [6:0] a);
        code_index = a[6] ? (7'(a[5:0]) + GROUP_SPAN) : a;
    endfunction : code_index

    assign code_idx   = code_index(ram_pointer_q);
    assign code_valid = (ram_pointer_q <= GROUP_LAST) ||
                        ((ram_pointer_q >= SECOND_BASE) && (ram_pointer_q <= SECOND_LAST));

    // ------------------------------------------------------------
    // Instruction decode, pointer and busy
    // ------------------------------------------------------------
    // Pointer steps after every data read and every data write not dropped as busy, wrapping inside its store
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ram_pointer_q <= 7'h00;
            glyph_sel_q   <= 1'b0;
            bus8_q        <= DL_RESET;
            disp_on_q     <= 1'b0;
            cursor_on_q   <= 1'b0;
        end else if ((wr_byte || rd_byte) && HOST_CTL_I.target_select) begin
            if (glyph_sel_q) begin
                ram_pointer_q <= {1'b0, ram_pointer_q[5:0] + 6'h01};
            end else if (ram_pointer_q == GROUP_LAST) begin
                ram_pointer_q <= SECOND_BASE;
            end else if (ram_pointer_q == SECOND_LAST) begin
                ram_pointer_q <= 7'h00;
            end else begin
                ram_pointer_q <= ram_pointer_q + 7'h01;
            end
        end else if (wr_byte) begin
            if (in_byte[7]) begin
                ram_pointer_q <= in_byte[6:0];
                glyph_sel_q   <= 1'b0;
            end else if (in_byte[6]) begin
                ram_pointer_q <= {1'b0, in_byte[5:0]};
                glyph_sel_q   <= 1'b1;
            end else if (in_byte[5]) begin
                bus8_q        <= in_byte[4];
            end else if (in_byte[3]) begin
                disp_on_q     <= in_byte[2];
                cursor_on_q   <= in_byte[1];
            end else if (in_byte[7:2] == 6'h00 && in_byte[1:0] != 2'b00) begin
                ram_pointer_q <= 7'h00;
                glyph_sel_q   <= 1'b0;
            end
        end
    end

    // Busy count; clear and home take the long figure
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            busy_cnt_q <= '0;
        end else if (wr_byte) begin
            busy_cnt_q <= (!HOST_CTL_I.target_select && in_byte[7:2] == 6'h00)
                          ? BUSY_W'(LONG_EXEC_CYCLES) : BUSY_W'(EXEC_CYCLES);
        end else if (busy_cnt_q != '0) begin
            busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
        end
    end
    assign internal_op_flag = (busy_cnt_q != '0);

    // ------------------------------------------------------------
    // Stores
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (wr_byte && HOST_CTL_I.target_select) begin
            if (glyph_sel_q) begin
                custom_glyph_ram[ram_pointer_q[5:0]] <= in_byte;
            end else if (code_valid) begin
                char_code_ram[code_idx] <= in_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        if (!HOST_CTL_I.target_select) begin
            rd_data = {internal_op_flag, ram_pointer_q};
        end else if (glyph_sel_q) begin
            rd_data = custom_glyph_ram[ram_pointer_q[5:0]];
        end else if (code_valid) begin
            rd_data = char_code_ram[code_idx];
        end else begin
            rd_data = 8'h00;
        end
        if (bus8_q || nib_q == NIB_HI) begin
            out_byte = rd_data;
        end else begin
            out_byte = {rd_data[3:0], 4'h0};
        end
    end

    // One cycle behind the strobe; the host samples late in the high phase
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            HOST_BUS_LINES_O    <= 8'h00;
            HOST_BUS_LINES_OE_O <= 1'b0;
        end else begin
            HOST_BUS_LINES_O    <= out_byte;
            HOST_BUS_LINES_OE_O <= HOST_CTL_I.strobe & HOST_CTL_I.dir_read;
        end
    end

    // ------------------------------------------------------------
    // Fixed glyphs
    // ------------------------------------------------------------
    // Stand-in pattern until the mask table is filled; codes past the
    // small-font range get the same stand-in pattern, with no 5 x 10 set
    function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [2:0] line);
        rom_row = code[4:0] ^ {5{line[0]}} ^ {2'b00, line};
    endfunction : rom_row

    // ------------------------------------------------------------
    // Row scan
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tick_q <= 16'h0000;
            row_q  <= 4'h0;
        end else if (tick_q == 16'(ROW_CYCLES - 1)) begin
            tick_q <= 16'h0000;
            row_q  <= row_q + 4'h1;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    // Lower eight commons serve cells 1..8, upper eight cells 9..16
    genvar c;
    generate
        for (c = 0; c < HALF_CELLS; c++) begin : g_cell
            logic [6:0] addr;
            logic [7:0] code;
            logic [4:0] dots;
            logic       at_cursor;
            assign addr = row_q[3] ? (SECOND_BASE + 7'(c)) : 7'(c);
            assign code = char_code_ram[code_index(addr)];
            assign at_cursor = cursor_on_q & ~glyph_sel_q & (ram_pointer_q == addr);
            always_comb begin
                if (code[7:4] == 4'h0) begin
                    dots = custom_glyph_ram[{code[2:0], row_q[2:0]}][4:0];
                end else begin
                    dots = rom_row(code, row_q[2:0]);
                end
                if (row_q[2:0] == CURSOR_LINE && at_cursor) begin
                    dots = 5'h1f;
                end
                seg_d[c*DOT_COLS +: DOT_COLS] = disp_on_q ? dots : 5'h00;
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            COMMON_ROW_O   <= 16'h0001;
            SEGMENT_DOTS_O <= 40'h00_0000_0000;
        end else begin
            COMMON_ROW_O   <= 16'h0001 << row_q;
            SEGMENT_DOTS_O <= seg_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);

    a_read_drive: assert property (HOST_BUS_LINES_OE_O ==
        $past(HOST_CTL_I.strobe & HOST_CTL_I.dir_read)) else $error("read drive off");
    a_status_read: assert property (HOST_CTL_I.strobe && HOST_CTL_I.dir_read &&
        !HOST_CTL_I.target_select && bus8_q |=> HOST_BUS_LINES_O == $past({internal_op_flag,
        ram_pointer_q})) else $error("status read wrong");
    a_busy_start: assert property (wr_byte |=> internal_op_flag [*8])
        else $error("busy not held after write");
    a_code_write: assert property (wr_byte && HOST_CTL_I.target_select &&
        !glyph_sel_q && code_valid |=> char_code_ram[$past(code_idx)] == $past(in_byte))
        else $error("code store not written");
    a_glyph_write: assert property (wr_byte && HOST_CTL_I.target_select &&
        glyph_sel_q |=> custom_glyph_ram[$past(ram_pointer_q[5:0])] == $past(in_byte))
        else $error("glyph store not written");
    a_group_wrap: assert property (wr_byte && HOST_CTL_I.target_select &&
        !glyph_sel_q && ram_pointer_q == GROUP_LAST |=> ram_pointer_q == SECOND_BASE)
        else $error("pointer did not jump to second group");
    a_nibble_pair: assert property (fall && !bus8_q && nib_q == NIB_HI |=>
        nib_q == NIB_LO && !$past(byte_done)) else $error("nibble pairing broken");
    a_width_set: assert property (wr_byte && !HOST_CTL_I.target_select &&
        in_byte[7:5] == 3'b001 |=> bus8_q == $past(in_byte[4]))
        else $error("bus width not updated");
    a_instr_ptr: assert property (wr_byte && !HOST_CTL_I.target_select && in_byte[7]
        |=> ram_pointer_q == $past(in_byte[6:0]) && !glyph_sel_q)
        else $error("address set failed");
    a_common_step: assert property (tick_q == 16'(ROW_CYCLES - 1) |=>
        ##1 COMMON_ROW_O == 16'h0001 << ($past(row_q, 2) + 4'h1)) else $error("row stuck");
    a_common_onehot: assert property ($onehot(COMMON_ROW_O))
        else $error("common rows not one-hot");

    c_four_bit_write: cover property (byte_done && !bus8_q && !HOST_CTL_I.dir_read);
    c_status_poll: cover property (rd_byte && !HOST_CTL_I.target_select && internal_op_flag);
    c_glyph_write: cover property (wr_byte && HOST_CTL_I.target_select && glyph_sel_q);
    c_upper_half: cover property (row_q[3] && disp_on_q);

endmodule : clhp_top

// File: bench/clhp_host_model.sv
// Behavioural host processor driving the display host port
`timescale 1ns/100ps
module clhp_host_model
    import clhp_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic [7:0]     bus_i,
    input  wire logic           oe_i,
    output clhp_pkg::clhp_ctl_t ctl_o,
    output logic      [7:0]     bus_o
);
    // ------------------------------------------------------------
    // Bus cycles, all changes just after a falling edge
    // ------------------------------------------------------------
    initial begin
        ctl_o = '0;
        bus_o = 8'h5a;
    end

    // One strobe carrying a byte, or a nibble on the upper lines
    task automatic strobe_write(input logic rs, input logic [7:0] d);
        @(negedge clk_i);
        ctl_o = '{target_select: rs, dir_read: 1'b0, strobe: 1'b1};
        bus_o = d;
        @(negedge clk_i);
        ctl_o.strobe = 1'b0;
        @(negedge clk_i);
        bus_o = ~d;  // Held one cycle past the fall, then released
    endtask : strobe_write

    // One read strobe, sampled after two high cycles
    task automatic strobe_read(input logic rs, output logic [8:0] r);
        @(negedge clk_i);
        ctl_o = '{target_select: rs, dir_read: 1'b1, strobe: 1'b1};
        bus_o = ~bus_o;
        @(negedge clk_i);
        @(negedge clk_i);
        r = {oe_i, bus_i};  // Device drives while strobe high
        ctl_o.strobe = 1'b0;
        @(negedge clk_i);
        bus_o = ~bus_o;  // Released lines keep changing so no stale value passes
    endtask : strobe_read

    // Whole byte, split high nibble first on a narrow bus
    task automatic write_unit(input logic rs, input logic [7:0] d, input logic four);
        if (four) begin
            strobe_write(rs, {d[7:4], 4'ha});
            strobe_write(rs, {d[3:0], 4'h5});
        end else begin
            strobe_write(rs, d);
        end
    endtask : write_unit

    // Whole byte read, nibbles joined on a narrow bus
    task automatic read_unit(input logic rs, input logic four, output logic [8:0] r);
        logic [8:0] r1;
        logic [8:0] r2;
        strobe_read(rs, r1);
        r = r1;
        if (four) begin
            strobe_read(rs, r2);
            r = {r1[8] & r2[8], r1[7:4], r2[7:4]};
        end
    endtask : read_unit
endmodule : clhp_host_model

// File: bench/clhp_top_bench.sv
// Self-checking bench for the character display host port
`timescale 1ns/100ps
`define CHK(g, e) check_val(16'(g), 16'(e))
module clhp_top_bench;
    import clhp_pkg::*;
    // Short counts keep the run brief; expectations follow them
    localparam int ROW_N = 4;
    typedef struct packed {
        logic       glyph;
        logic [6:0] addr;
        logic [7:0] data;
        logic [7:0] expd;
        logic [7:0] ptr;   // 8'hff: pointer not checked
    } clhp_row_t;
    localparam clhp_row_t ROWS [8] = '{
        '{1'b0, 7'h00, 8'h00, 8'h00, 8'h01}, '{1'b0, 7'h41, 8'h08, 8'h08, 8'h42},
        '{1'b0, 7'h07, 8'h3c, 8'h3c, 8'h08}, '{1'b0, 7'h27, 8'h5a, 8'h5a, 8'h40},
        '{1'b0, 7'h67, 8'h81, 8'h81, 8'h00}, '{1'b0, 7'h30, 8'h77, 8'h00, 8'hff},
        '{1'b1, 7'h02, 8'h15, 8'h15, 8'h03}, '{1'b1, 7'h3f, 8'h1e, 8'h1e, 8'h00}
    };
    logic         clk;
    logic         rst_b;
    clhp_ctl_t    ctl;
    logic [7:0]   host_bus;
    logic [7:0]   dout;
    logic         oe;
    logic [15:0]  row;
    logic [39:0]  seg;
    wire  [7:0]   bus_wire;
    int           err_total;
    int           compares;
    logic         four;
    logic [8:0]   r;
    clhp_row_t    t;

    // Wire level: device wins while it drives
    assign bus_wire = oe ? dout : host_bus;

    clhp_top #(.EXEC_CYCLES(16), .LONG_EXEC_CYCLES(64), .ROW_CYCLES(ROW_N)) i_dut (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .HOST_CTL_I(ctl), .HOST_BUS_LINES_I(bus_wire),
        .HOST_BUS_LINES_O(dout), .HOST_BUS_LINES_OE_O(oe), .COMMON_ROW_O(row),
        .SEGMENT_DOTS_O(seg)
    );
    clhp_host_model i_host (
        .clk_i(clk), .bus_i(bus_wire), .oe_i(oe), .ctl_o(ctl), .bus_o(host_bus)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic finish_test();
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic rs, input logic [7:0] d);
        i_host.write_unit(rs, d, four);
    endtask : wr

    task automatic rd(input logic rs, output logic [8:0] v);
        i_host.read_unit(rs, four, v);
    endtask : rd

    // Status polling; a stuck busy flag ends the run
    task automatic poll();
        logic [8:0] v;
        for (int n = 0; n < 400; n++) begin
            rd(1'b0, v);
            if (v[7] === 1'b0) return;
        end
        err_total++;
        finish_test();
    endtask : poll

    task automatic wait_row(input logic [15:0] m);
        for (int n = 0; n < 200; n++) begin
            @(negedge clk);
            if (row === m) return;
        end
        err_total++;
        finish_test();
    endtask : wait_row

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        compares = 0;
        four = 1'b0;
        rst_b = 1'b0;
        repeat (8) @(negedge clk);
        `CHK(oe, 1'b0);
        `CHK(row, 16'h0001);
        `CHK(|seg, 1'b0);
        rst_b = 1'b1;
        // Table rows: write, busy, pointer, read back
        foreach (ROWS[i]) begin
            t = ROWS[i];
            wr(1'b0, t.glyph ? {2'b01, t.addr[5:0]} : {1'b1, t.addr});
            poll();
            wr(1'b1, t.data);
            rd(1'b0, r);
            `CHK(r[7], 1'b1);
            poll();
            rd(1'b0, r);
            if (t.ptr != 8'hff) `CHK(r[6:0], t.ptr[6:0]);
            wr(1'b0, t.glyph ? {2'b01, t.addr[5:0]} : {1'b1, t.addr});
            poll();
            rd(1'b1, r);
            `CHK(r, {1'b1, t.expd});
            poll();
        end
        // Display on, then one full scan and two dot slices
        wr(1'b0, 8'h0c);
        poll();
        wait_row(16'h8000);
        wait_row(16'h0001);
        for (int k = 1; k <= 16; k++) begin
            repeat (ROW_N) @(negedge clk);
            `CHK(row, 16'h0001 << (k % 16));
        end
        wait_row(16'h0004);
        `CHK(seg[4:0], 5'h15);
        `CHK(seg[39:35], 5'h1e);
        wait_row(16'h0400);
        `CHK(seg[9:5], 5'h15);
        // Write while busy is dropped
        wr(1'b0, 8'h90);
        poll();
        wr(1'b1, 8'h11);
        wr(1'b1, 8'h22);
        poll();
        rd(1'b0, r);
        `CHK(r[6:0], 7'h11);
        wr(1'b0, 8'h90);
        poll();
        rd(1'b1, r);
        `CHK(r[7:0], 8'h11);
        // Clear runs longer than an ordinary write
        poll();
        wr(1'b0, 8'h01);
        repeat (30) @(negedge clk);
        rd(1'b0, r);
        `CHK(r[7], 1'b1);
        poll();
        rd(1'b0, r);
        `CHK(r[6:0], 7'h00);
        // Cursor line shows a full bar at the pointer's cell
        wr(1'b0, 8'h0e);
        poll();
        wait_row(16'h0080);
        `CHK(seg[4:0], 5'h1f);
        // Narrow bus round trip, then back to the wide bus
        wr(1'b0, 8'h20);
        four = 1'b1;
        poll();
        wr(1'b0, 8'h85);
        poll();
        wr(1'b1, 8'h9c);
        poll();
        wr(1'b0, 8'h85);
        poll();
        rd(1'b1, r);
        `CHK(r[7:0], 8'h9c);
        poll();
        wr(1'b0, 8'h30);
        four = 1'b0;
        poll();
        rd(1'b0, r);
        `CHK(r[7:0], 8'h06);
        // Second reset in mid-run clears pointer and busy
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(row, 16'h0001);
        rst_b = 1'b1;
        rd(1'b0, r);
        `CHK(r[7:0], 8'h00);
        finish_test();
    end
endmodule : clhp_top_bench
